// ---- tsc_pkg.sv ----
// Shared constants and types for the touch sensor register bank and its host
package tsc_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int TICK_MS          = 16;
  localparam int TICK_CYCLES_DFLT = TICK_MS * CLK_MHZ * 1000;
  localparam int DRIFT_UNIT_MS    = 160;
  localparam int DRIFT_UNIT_TICKS = DRIFT_UNIT_MS / TICK_MS;
  localparam int SOFT_RESET_TICKS = 2;

  // ---------------------------------------------------------------------
  // Device register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_DEVICE_IDENTIFIER  = 8'h00;
  localparam logic [7:0] REG_FIRMWARE_VERSION   = 8'h01;
  localparam logic [7:0] REG_GENERAL_STATUS     = 8'h02;
  localparam logic [7:0] REG_KEY_DETECT_LOW     = 8'h03;
  localparam logic [7:0] REG_KEY_DETECT_HIGH    = 8'h04;
  localparam logic [7:0] REG_SLIDER_POSITION    = 8'h05;
  localparam logic [7:0] REG_PIN_INPUT_LEVELS   = 8'h06;
  localparam logic [7:0] REG_FIRMWARE_SUBREV    = 8'h07;
  localparam logic [7:0] REG_RECALIBRATE_CMD    = 8'h0A;
  localparam logic [7:0] REG_SOFT_RESET_CMD     = 8'h0B;
  localparam logic [7:0] REG_SLEEP_INTERVAL     = 8'h0C;
  localparam logic [7:0] REG_BURST_REPEAT       = 8'h0D;
  localparam logic [7:0] REG_FALLING_DRIFT_RATE = 8'h0F;
  localparam logic [7:0] REG_RISING_DRIFT_RATE  = 8'h10;
  localparam logic [7:0] REG_CONFIRM_LIMIT      = 8'h11;

  // ---------------------------------------------------------------------
  // Fields, masks and reset values
  // ---------------------------------------------------------------------
  localparam int         STATUS_BYTES   = 5;
  localparam int         PIN_LSB        = 2;
  localparam logic [7:0] BURST_MASK     = 8'h3F;
  localparam logic [7:0] DRIFT_MASK     = 8'h7F;
  localparam logic [7:0] CONFIRM_MASK   = 8'h1F;
  localparam logic [7:0] SLEEP_RST      = 8'h01;
  localparam logic [7:0] BURST_RST      = 8'h01;
  localparam logic [7:0] FALL_RST       = 8'h14;
  localparam logic [7:0] RISE_RST       = 8'h05;
  localparam logic [7:0] CONFIRM_RST    = 8'h03;
  localparam logic [4:0] CHG_RST        = 5'h01;

  // ---------------------------------------------------------------------
  // Host command port
  // ---------------------------------------------------------------------
  localparam logic [3:0] HOST_CMD_ADDR  = 4'h0;
  localparam logic [3:0] HOST_STAT_ADDR = 4'h4;
  localparam int         CMD_ADDR_LSB   = 8;
  localparam int         CMD_WE_BIT     = 16;
  localparam int         STAT_BUSY_BIT  = 8;
  localparam int         STAT_NACK_BIT  = 9;
  localparam int         STAT_CHG_BIT   = 10;
  localparam int         STAT_DONE_BIT  = 11;

  // ---------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------
  typedef enum logic [0:0] {
    TSC_RUN     = 1'b0,
    TSC_QUIESCE = 1'b1
  } tsc_soft_t;

  typedef enum logic [0:0] {
    TSC_H_IDLE = 1'b0,
    TSC_H_WAIT = 1'b1
  } tsc_host_t;

endpackage

// ---- tsc_link_if.sv ----
// Register access link and change alert between host and device
`timescale 1ns/1ps
interface tsc_link_if;
  logic       link_req;
  logic       link_we;
  logic [7:0] link_addr;
  logic [7:0] link_wdata;
  logic [7:0] link_rdata;
  logic       link_ack;
  logic       link_nack;
  logic       change_n;

  modport dev (
    input  link_req, link_we, link_addr, link_wdata,
    output link_rdata, link_ack, link_nack, change_n
  );
  modport host (
    output link_req, link_we, link_addr, link_wdata,
    input  link_rdata, link_ack, link_nack, change_n
  );
endinterface // tsc_link_if

// ---- tsc_dev_end.sv ----
// Device end: status and configuration byte registers with acquisition pacing
//
// Implementation choice: the tsc_link_if device-side register access link.
`timescale 1ns/1ps
module tsc_dev_end
  import tsc_pkg::*;
#(
  parameter int         TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter logic [7:0] DEVICE_ID   = 8'h5A, // Arbitrary value
  parameter logic [7:0] FW_VERSION  = 8'h21, // Arbitrary value
  parameter logic [7:0] FW_SUBREV   = 8'h03  // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Host link
  tsc_link_if.dev          lnk,
  // Acquisition front end
  output logic             acq_start,
  output logic [5:0]       burst_count,
  input  wire logic        acq_done,
  input  wire logic [15:0] key_over,
  input  wire logic        slider_touch,
  input  wire logic [7:0]  slider_pos,
  input  wire logic        common_shift,
  input  wire logic        common_none,
  // General-purpose pins
  input  wire logic [2:0]  gpio_level,
  input  wire logic [2:0]  gpio_is_out,
  // Results and controls
  output logic [15:0]      key_touched,
  output logic             recal_pulse,
  output logic             drift_fall_step,
  output logic             drift_rise_step,
  output logic [15:0]      drift_allow
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic            rst;
  logic            fire_q;
  tsc_soft_t       soft_st_q;
  logic [1:0]      soft_cnt_q;
  logic [TW-1:0]   tick_cnt_q;
  logic            tick_q;
  logic [7:0]      sleep_cnt_q;
  logic            busy_q;
  logic            acq_start_q;
  logic [5:0]      burst_count_q;
  logic [TW-1:0]   acq_cyc_q;
  logic            late_q;
  logic            slider_touch_flag_q;
  logic            cc_q;
  logic [7:0]      pos_q;
  logic [7:0]      pin_q;
  logic            rst_flag_q;
  logic [4:0]      chg_q;
  logic [7:0]      stat_prev_q [STATUS_BYTES];
  wire  [7:0]      stat_now [STATUS_BYTES];
  wire  [4:0]      chg_set;
  logic [4:0]      rd_clr;
  logic            change_n_q;
  logic            ack_q;
  logic            nack_q;
  logic [7:0]      rdata_q;
  logic [7:0]      cal_q;
  logic [7:0]      srst_q;
  logic [7:0]      sleep_q;
  logic [7:0]      burst_q;
  logic [7:0]      fall_q;
  logic [7:0]      rise_q;
  logic [7:0]      confirm_q;
  logic            recal_q;
  logic [7:0]      rd_mux;
  logic            take;
  logic            done;
  wire  [15:0]     tch_w;
  wire  [15:0]     allow_w;
  wire  [1:0]      step_w;
  wire  [7:0]      gen_byte;
  wire  [5:0]      limit1;

  assign rst      = !resetn || fire_q;
  assign done     = ce && acq_done && busy_q;
  assign take     = ce && lnk.link_req && !ack_q && !nack_q;
  assign limit1   = {1'b0, confirm_q[4:0]} + 6'h01;
  assign gen_byte = {rst_flag_q, late_q, 4'h0, cc_q, slider_touch_flag_q};

  // ---------------------------------------------------------------------
  // Acquisition pacing
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce) begin
      if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= '0;
        tick_q     <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_q     <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_cnt_q   <= 8'h00;
      busy_q        <= 1'b0;
      acq_start_q   <= 1'b0;
      burst_count_q <= 6'h00;
    end else if (ce) begin
      acq_start_q <= 1'b0;
      if (acq_done && busy_q) begin
        busy_q <= 1'b0;
      end
      if (tick_q) begin
        if (sleep_q == 8'h00) begin
          sleep_cnt_q <= 8'h00;
        end else if (sleep_cnt_q >= sleep_q - 8'h01) begin
          sleep_cnt_q <= 8'h00;
          if (!busy_q) begin
            acq_start_q   <= 1'b1;
            busy_q        <= 1'b1;
            burst_count_q <= burst_q[5:0];
          end
        end else begin
          sleep_cnt_q <= sleep_cnt_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acq_cyc_q <= '0;
      late_q    <= 1'b0;
    end else if (ce) begin
      if (acq_start_q) begin
        acq_cyc_q <= '0;
      end else if (busy_q && acq_cyc_q != TW'(TICK_CYCLES)) begin
        acq_cyc_q <= acq_cyc_q + 1'b1;
      end
      if (busy_q && acq_cyc_q == TW'(TICK_CYCLES)) begin
        late_q <= 1'b1;
      end else if (acq_done && busy_q) begin
        late_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Acquisition results
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      slider_touch_flag_q <= 1'b0;
      cc_q   <= 1'b1;
      pos_q  <= 8'h00;
      pin_q  <= 8'h00;
    end else if (done) begin
      slider_touch_flag_q <= slider_touch;
      cc_q   <= common_none || common_shift;
      pos_q  <= slider_pos;
      pin_q  <= {3'h0, gpio_level & ~gpio_is_out, 2'h0};
    end
  end

  for (genvar k = 0; k < 16; k++) begin : g_key
    logic [5:0] di_q;
    logic       tch_q;
    logic       allow_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        di_q    <= 6'h00;
        tch_q   <= 1'b0;
        allow_q <= 1'b1;
      end else if (done) begin
        allow_q <= !key_over[k];
        if (key_over[k]) begin
          if (di_q < limit1) begin
            di_q <= di_q + 6'h01;
          end
          tch_q <= (di_q + 6'h01 >= limit1);
        end else begin
          di_q  <= 6'h00;
          tch_q <= 1'b0;
        end
      end
    end
    assign tch_w[k]   = tch_q;
    assign allow_w[k] = allow_q;
  end

  for (genvar d = 0; d < 2; d++) begin : g_drift
    logic [10:0] cnt_q;
    logic        step_q;
    wire  [6:0]  rate;
    wire  [10:0] lim;
    assign rate = (d == 0) ? fall_q[6:0] : rise_q[6:0];
    assign lim  = 11'(int'(rate) * DRIFT_UNIT_TICKS);
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_q  <= 11'h000;
        step_q <= 1'b0;
      end else if (ce) begin
        step_q <= 1'b0;
        if (rate == 7'h00) begin
          cnt_q <= 11'h000;
        end else if (tick_q) begin
          if (cnt_q >= lim - 11'h001) begin
            cnt_q  <= 11'h000;
            step_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 11'h001;
          end
        end
      end
    end
    assign step_w[d] = step_q;
  end

  // ---------------------------------------------------------------------
  // Change tracking
  // ---------------------------------------------------------------------
  assign stat_now[0] = {1'b0, gen_byte[6:0]};
  assign stat_now[1] = tch_w[7:0];
  assign stat_now[2] = tch_w[15:8];
  assign stat_now[3] = pos_q;
  assign stat_now[4] = pin_q;

  for (genvar s = 0; s < STATUS_BYTES; s++) begin : g_chg
    assign chg_set[s] = (stat_now[s] != stat_prev_q[s]);
    always_ff @(posedge clk) begin
      if (rst) begin
        stat_prev_q[s] <= (s == 0) ? 8'h03 : 8'h00;
      end else if (ce) begin
        stat_prev_q[s] <= stat_now[s];
      end
    end
    assign rd_clr[s] = take && !lnk.link_we && soft_st_q == TSC_RUN &&
                       lnk.link_addr == REG_GENERAL_STATUS + 8'(s);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chg_q      <= CHG_RST;
      rst_flag_q <= 1'b1;
      change_n_q <= 1'b1;
    end else if (ce) begin
      chg_q      <= chg_set | (chg_q & ~rd_clr);
      if (rd_clr[0]) begin
        rst_flag_q <= 1'b0;
      end
      change_n_q <= !(|chg_q) || soft_st_q == TSC_QUIESCE;
    end
  end

  // ---------------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (lnk.link_addr == REG_DEVICE_IDENTIFIER) begin
      rd_mux = DEVICE_ID;
    end else if (lnk.link_addr == REG_FIRMWARE_VERSION) begin
      rd_mux = FW_VERSION;
    end else if (lnk.link_addr == REG_GENERAL_STATUS) begin
      rd_mux = gen_byte;
    end else if (lnk.link_addr == REG_KEY_DETECT_LOW) begin
      rd_mux = tch_w[7:0];
    end else if (lnk.link_addr == REG_KEY_DETECT_HIGH) begin
      rd_mux = tch_w[15:8];
    end else if (lnk.link_addr == REG_SLIDER_POSITION) begin
      rd_mux = pos_q;
    end else if (lnk.link_addr == REG_PIN_INPUT_LEVELS) begin
      rd_mux = pin_q;
    end else if (lnk.link_addr == REG_FIRMWARE_SUBREV) begin
      rd_mux = FW_SUBREV;
    end else if (lnk.link_addr == REG_RECALIBRATE_CMD) begin
      rd_mux = cal_q;
    end else if (lnk.link_addr == REG_SOFT_RESET_CMD) begin
      rd_mux = srst_q;
    end else if (lnk.link_addr == REG_SLEEP_INTERVAL) begin
      rd_mux = sleep_q;
    end else if (lnk.link_addr == REG_BURST_REPEAT) begin
      rd_mux = burst_q;
    end else if (lnk.link_addr == REG_FALLING_DRIFT_RATE) begin
      rd_mux = fall_q;
    end else if (lnk.link_addr == REG_RISING_DRIFT_RATE) begin
      rd_mux = rise_q;
    end else if (lnk.link_addr == REG_CONFIRM_LIMIT) begin
      rd_mux = confirm_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q     <= 1'b0;
      nack_q    <= 1'b0;
      rdata_q   <= 8'h00;
      cal_q     <= 8'h00;
      srst_q    <= 8'h00;
      sleep_q   <= SLEEP_RST;
      burst_q   <= BURST_RST;
      fall_q    <= FALL_RST;
      rise_q    <= RISE_RST;
      confirm_q <= CONFIRM_RST;
      recal_q   <= 1'b0;
    end else if (ce) begin
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
      recal_q <= 1'b0;
      if (take && soft_st_q == TSC_QUIESCE) begin
        nack_q <= 1'b1;
      end else if (take) begin
        ack_q   <= 1'b1;
        rdata_q <= rd_mux;
        if (lnk.link_we) begin
          if (lnk.link_addr == REG_RECALIBRATE_CMD) begin
            cal_q   <= lnk.link_wdata;
            recal_q <= (lnk.link_wdata != 8'h00);
          end else if (lnk.link_addr == REG_SOFT_RESET_CMD) begin
            srst_q <= lnk.link_wdata;
          end else if (lnk.link_addr == REG_SLEEP_INTERVAL) begin
            sleep_q <= lnk.link_wdata;
          end else if (lnk.link_addr == REG_BURST_REPEAT) begin
            burst_q <= lnk.link_wdata & BURST_MASK;
          end else if (lnk.link_addr == REG_FALLING_DRIFT_RATE) begin
            fall_q <= lnk.link_wdata & DRIFT_MASK;
          end else if (lnk.link_addr == REG_RISING_DRIFT_RATE) begin
            rise_q <= lnk.link_wdata & DRIFT_MASK;
          end else if (lnk.link_addr == REG_CONFIRM_LIMIT) begin
            confirm_q <= lnk.link_wdata & CONFIRM_MASK;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Soft reset sequencing
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_st_q  <= TSC_RUN;
      soft_cnt_q <= 2'h0;
      fire_q     <= 1'b0;
    end else if (ce) begin
      case (soft_st_q)
        TSC_RUN: begin
          if (take && lnk.link_we && lnk.link_addr == REG_SOFT_RESET_CMD &&
              lnk.link_wdata != 8'h00) begin
            soft_st_q  <= TSC_QUIESCE;
            soft_cnt_q <= 2'h0;
          end
        end
        TSC_QUIESCE: begin
          if (tick_q) begin
            soft_cnt_q <= soft_cnt_q + 2'h1;
          end
          if (soft_cnt_q == 2'(SOFT_RESET_TICKS)) begin
            fire_q <= 1'b1;
          end
        end
        default: soft_st_q <= TSC_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign lnk.link_ack    = ack_q;
  assign lnk.link_nack   = nack_q;
  assign lnk.link_rdata  = rdata_q;
  assign lnk.change_n    = change_n_q;
  assign acq_start       = acq_start_q;
  assign burst_count     = burst_count_q;
  assign key_touched     = tch_w;
  assign recal_pulse     = recal_q;
  assign drift_fall_step = step_w[0];
  assign drift_rise_step = step_w[1];
  assign drift_allow     = allow_w;

endmodule // tsc_dev_end

// ---- tsc_host_end.sv ----
// Host end: Avalon-MM command port driving the register access link
`timescale 1ns/1ps
module tsc_host_end
  import tsc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Device link
  tsc_link_if.host         lnk
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic        wait_q;
  logic [31:0] readdata_q;
  tsc_host_t   st_q;
  logic        req_q;
  logic        we_q;
  logic [7:0]  addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        nack_q;
  logic        done_q;
  logic        accept;
  logic [31:0] stat_word;

  assign accept    = ce && !wait_q && avs_write &&
                     avs_address == HOST_CMD_ADDR;
  assign stat_word = {20'h0_0000, done_q, !lnk.change_n, nack_q,
                      st_q == TSC_H_WAIT, rdata_q};

  // ---------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_q     <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (!wait_q) begin
        wait_q <= 1'b1;
      end else if (avs_read || avs_write) begin
        wait_q <= 1'b0;
        if (avs_read && avs_address == HOST_STAT_ADDR) begin
          readdata_q <= stat_word;
        end else if (avs_read && avs_address == HOST_CMD_ADDR) begin
          readdata_q <= {15'h0000, we_q, addr_q, wdata_q};
        end else begin
          readdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Link sequencing
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q    <= TSC_H_IDLE;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      nack_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (ce) begin
      case (st_q)
        TSC_H_IDLE: begin
          if (accept) begin
            req_q   <= 1'b1;
            we_q    <= avs_writedata[CMD_WE_BIT];
            addr_q  <= avs_writedata[CMD_ADDR_LSB +: 8];
            wdata_q <= avs_writedata[7:0];
            done_q  <= 1'b0;
            st_q    <= TSC_H_WAIT;
          end
        end
        TSC_H_WAIT: begin
          if (lnk.link_ack || lnk.link_nack) begin
            req_q   <= 1'b0;
            nack_q  <= lnk.link_nack;
            rdata_q <= lnk.link_ack ? lnk.link_rdata : 8'h00;
            done_q  <= 1'b1;
            st_q    <= TSC_H_IDLE;
          end
        end
        default: st_q <= TSC_H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = wait_q;
  assign lnk.link_req    = req_q;
  assign lnk.link_we     = we_q;
  assign lnk.link_addr   = addr_q;
  assign lnk.link_wdata  = wdata_q;

endmodule // tsc_host_end

// ---- tsc_link_chk.sv ----
// Concurrent checks on the link between host end and device end
`timescale 1ns/1ps
module tsc_link_chk
  import tsc_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID  = 8'h5A, // Arbitrary value
  parameter logic [7:0] FW_VERSION = 8'h21  // Arbitrary value
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Link
  input wire logic       link_we,
  input wire logic [7:0] link_addr,
  input wire logic [7:0] link_wdata,
  input wire logic [7:0] link_rdata,
  input wire logic       link_ack,
  input wire logic       change_n
);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd;
  assign rd = link_ack && !link_we;
  id_read_a: assert property (rd && link_addr == 8'h00 |->
    link_rdata == DEVICE_ID) else $error("Bad id byte");
  version_read_a: assert property (rd && link_addr == 8'h01 |->
    link_rdata == FW_VERSION) else $error("Bad version byte");
  pin_zero_a: assert property (rd && link_addr == 8'h06 |->
    link_rdata[7:5] == 3'h0 && link_rdata[1:0] == 2'h0)
    else $error("Pin byte fixed bits set");
  status_zero_a: assert property (rd && link_addr == 8'h02 |->
    link_rdata[5:2] == 4'h0) else $error("Status fixed bits set");
  burst_mask_a: assert property (rd && link_addr == 8'h0D |->
    link_rdata[7:6] == 2'h0) else $error("Burst byte too wide");
  confirm_mask_a: assert property (rd && link_addr == 8'h11 |->
    link_rdata[7:5] == 3'h0) else $error("Confirm byte too wide");
  reset_alert_a: assert property ($rose(resetn) |->
    ##[1:3] !change_n) else $error("No alert after reset");
  quiesce_a: assert property (link_ack && link_we &&
    link_addr == 8'h0B && link_wdata != 8'h00 |-> ##3 change_n [*8])
    else $error("Alert kept during soft reset");
  cover property (rd && link_addr == 8'h02);
  cover property (link_ack && link_we);
  cover property ($rose(change_n));
endmodule // tsc_link_chk

// ---- tsc_test.sv ----
// Self-checking bench for the joined host and device ends
`timescale 1ns/1ps
module tsc_test
  import tsc_pkg::*;
;
  // ---------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------
  logic        clk = 0;
  logic        resetn = 0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        acq_start;
  logic        acq_done = 0;
  logic [7:0]  v = 8'h00;
  logic [31:0] s;
  int          miscompares = 0;
  int          checks = 0;
  logic [15:0] kt;
  logic [15:0] allow;
  logic [5:0]  bc;
  logic        rp;
  logic        fs;
  logic        rs;
  int          recals = 0;
  int          rises = 0;
  int          falls = 0;
  int          acqs = 0;
  int          r0 = 0;
  int          r1 = 0;
  int          r2 = 0;
  logic [7:0]  da [9] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h0C, 8'h0D,
                         8'h0F, 8'h10, 8'h11};
  logic [7:0]  dv [9] = '{8'h5A, 8'h21, 8'h03, 8'h00, 8'h01, 8'h01,
                         8'h14, 8'h05, 8'h03};
  always #2.5 clk = ~clk;
  always @(posedge clk) acq_done <= acq_start;
  always @(posedge clk) begin
    recals <= recals + int'(rp);
    rises <= rises + int'(rs);
    falls <= falls + int'(fs);
    acqs <= acqs + int'(acq_start);
  end
  tsc_link_if i_tsc_link_if ();
  tsc_dev_end #(.TICK_CYCLES(20)) i_tsc_dev_end (
    .clk(clk), .resetn(resetn), .ce(1'b1), .lnk(i_tsc_link_if.dev),
    .acq_start(acq_start), .burst_count(bc), .acq_done(acq_done),
    .key_over({v, v}), .slider_touch(v[0]), .slider_pos(v),
    .common_shift(v[1]), .common_none(!v[4]),
    .gpio_level({v[2], 1'b1, v[0]}), .gpio_is_out(3'b010),
    .key_touched(kt), .recal_pulse(rp), .drift_fall_step(fs),
    .drift_rise_step(rs), .drift_allow(allow));
  tsc_host_end i_tsc_host_end (
    .clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(i_tsc_link_if.host));
  tsc_link_chk i_tsc_link_chk (
    .clk(clk), .resetn(resetn), .link_we(i_tsc_link_if.link_we),
    .link_addr(i_tsc_link_if.link_addr),
    .link_wdata(i_tsc_link_if.link_wdata),
    .link_rdata(i_tsc_link_if.link_rdata),
    .link_ack(i_tsc_link_if.link_ack), .change_n(i_tsc_link_if.change_n));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    s = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [7:0] d);
    av(1'b1, HOST_CMD_ADDR, {15'h0000, we, a, d});
    s = 32'h0000_0000;
    for (int i = 0; i < 50 && s[STAT_DONE_BIT] !== 1'b1; i++)
      av(1'b0, HOST_STAT_ADDR, 32'h0000_0000);
    if (s[STAT_DONE_BIT] !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(s[7:0], e);
  endtask
  // ---------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    repeat (60) @(posedge clk);
    for (int i = 0; i < 9; i++) rd(da[i], dv[i]);
    rd(REG_GENERAL_STATUS, 8'h82);
    rd(REG_GENERAL_STATUS, 8'h02);
    v <= 8'h15;
    repeat (300) @(posedge clk);
    chk({7'h00, i_tsc_link_if.change_n}, 8'h00);
    rd(REG_GENERAL_STATUS, 8'h01);
    rd(REG_KEY_DETECT_LOW, 8'h15);
    chk(kt[7:0], 8'h15);
    chk(allow[7:0], 8'hEA);
    rd(REG_KEY_DETECT_HIGH, 8'h15);
    rd(REG_SLIDER_POSITION, 8'h15);
    rd(REG_PIN_INPUT_LEVELS, 8'h14);
    repeat (3) @(posedge clk);
    chk({7'h00, i_tsc_link_if.change_n}, 8'h01);
    acc(1'b1, REG_BURST_REPEAT, 8'hFF);
    rd(REG_BURST_REPEAT, 8'h3F);
    acc(1'b1, REG_CONFIRM_LIMIT, 8'hFF);
    rd(REG_CONFIRM_LIMIT, 8'h1F);
    chk({2'h0, bc}, 8'h3F);
    acc(1'b1, REG_RECALIBRATE_CMD, 8'h01);
    rd(REG_RECALIBRATE_CMD, 8'h01);
    chk(8'(recals), 8'h01);
    acc(1'b1, REG_SOFT_RESET_CMD, 8'h01);
    acc(1'b1, REG_SLEEP_INTERVAL, 8'h07);
    chk({7'h00, s[STAT_NACK_BIT]}, 8'h01);
    repeat (100) @(posedge clk);
    rd(REG_BURST_REPEAT, 8'h01);
    rd(REG_SLEEP_INTERVAL, 8'h01);
    acc(1'b1, REG_RISING_DRIFT_RATE, 8'h00);
    acc(1'b1, REG_FALLING_DRIFT_RATE, 8'h01);
    acc(1'b1, REG_SLEEP_INTERVAL, 8'h00);
    repeat (250) @(posedge clk);
    @(negedge clk);
    r0 = falls;
    r1 = rises;
    r2 = acqs;
    repeat (400) @(negedge clk);
    chk(8'(falls - r0), 8'h02);
    chk(8'(rises - r1), 8'h00);
    chk(8'(acqs - r2), 8'h00);
    end_of_test();
  end
endmodule // tsc_test
